// *** pdm_capture_defs.vh ***
// Register map, field layout, reset values and timing counts of the microphone capture block
// Behaviour
// RQ1 - Stereo word: right high half, left low
// RQ2 - Mono word: earlier sample low, later high
// RQ3 - Samples stored in little-endian byte order
// RQ4 - Buffer length counts samples, two bytes each
// RQ5 - Software sets pointer and length before start
// RQ6 - Buffer pointer is double-buffered after begun event
// RQ7 - Full buffer raises event, continues without gap
// RQ8 - New buffer raises fresh capture-begun event
// RQ9 - Buffer-full also fires after halt completes
// RQ10 - Software discards about fifty initial samples
// RQ11 - Software keeps pointer inside data RAM
// RQ12 - Disconnected route drives no physical pin
// RQ13 - Pin routing applies only while enabled
// RQ14 - Software presets clock pin low, data input
// RQ15 - One driver per physical pin only
// RQ16 - Two microphones strapped left and right
// RQ17 - Write one starts or halts capture
// RQ18 - Event registers read one once generated
// RQ19 - Interrupt enable bits: begun, halted, full
// RQ20 - Set and clear registers write ones only
// RQ21 - Edge bit selects which edge samples left
// RQ22 - Halt waits for frame, then halted event (code waits only for the pending word write, not for the frame to end)
// RQ23 - DMA address advances one word per store
`ifndef PDM_CAPTURE_DEFS_VH
`define PDM_CAPTURE_DEFS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_BEGIN 12'h000
`define OFS_HALT 12'h004
`define OFS_BEGUN 12'h100
`define OFS_HALTED 12'h104
`define OFS_FULL 12'h108
`define OFS_IRQ_MASK 12'h300
`define OFS_IRQ_SET 12'h304
`define OFS_IRQ_CLR 12'h308
`define OFS_BLOCK_ON 12'h500
`define OFS_DIVIDER 12'h504
`define OFS_ROUTING 12'h508
`define OFS_LEFT_VOL 12'h518
`define OFS_RIGHT_VOL 12'h51c
`define OFS_CLK_PIN 12'h540
`define OFS_DIN_PIN 12'h544
`define OFS_PTR 12'h560
`define OFS_LEN 12'h564

// ----------------------------------------
// Field positions
// ----------------------------------------
`define BIT_EV_BEGUN 0
`define BIT_EV_HALTED 1
`define BIT_EV_FULL 2
`define BIT_MONO 0
`define BIT_EDGE 1
`define BIT_CONNECT 31
`define PIN_MSB 4
`define LEN_MSB 14
`define VOL_MSB 6

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_DIVIDER 32'h08400000
`define RST_VOL 7'h28
`define RST_PIN 32'hffffffff

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ 20
`define MIC_HALF_NS 500
`define BITS_PER_FRAME 64

`endif

// *** bit_decimator.v ***
// One channel of bit counting decimation with volume scaling
`timescale 1ns/1ps
`default_nettype none
`include "pdm_capture_defs.vh"

module bit_decimator (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire clear,
  input wire bit_valid,
  input wire bit_in,
  input wire [`VOL_MSB:0] gain,
  output reg [15:0] sample,
  output reg sample_valid
);

  reg [5:0] bit_cnt; // Bits gathered in this frame
  reg [6:0] ones; // Ones gathered in this frame

  // Signed density around mid scale, times gain step plus one, times eight
  // Worst case 32 * 128 * 8 overflows 16 bits and wraps, as no clipping is done
  function [15:0] scale;
    input [6:0] o;
    input [6:0] g;
    reg signed [8:0] d;
    reg signed [8:0] m;
    reg signed [17:0] p;
    begin
      d = $signed({2'b00, o}) - 9'sd32;
      m = $signed({2'b00, g}) + 9'sd1;
      p = d * m;
      scale = {p[12:0], 3'b000};
    end
  endfunction

  // ----------------------------------------
  // Frame counter
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_cnt <= 6'h00;
      ones <= 7'h00;
      sample <= 16'h0000;
      sample_valid <= 1'b0;
    end else if (clk_en) begin
      sample_valid <= 1'b0;
      if (clear) begin
        // Idle: start the next frame from scratch
        bit_cnt <= 6'h00;
        ones <= 7'h00;
      end else if (bit_valid) begin
        bit_cnt <= bit_cnt + 6'h01;
        if (bit_cnt == 6'h3f) begin
          // Last bit of the frame closes the sample
          sample <= scale(ones + {6'h00, bit_in}, gain);
          sample_valid <= 1'b1;
          ones <= 7'h00;
        end else begin
          ones <= ones + {6'h00, bit_in};
        end
      end
    end
  end

endmodule
`default_nettype wire

// *** pdm_capture.v ***
// Microphone capture block: APB registers, clock out, packing and DMA writes
`timescale 1ns/1ps
`default_nettype none
`include "pdm_capture_defs.vh"

module pdm_capture (
  input wire pclk,
  input wire presetn,
  input wire clk_en,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg dma_req,
  output reg [31:0] dma_addr,
  output reg [31:0] dma_wdata,
  input wire dma_ack,
  output reg mic_clock_out,
  output reg mic_clock_oe,
  input wire data_pin,
  output reg [`PIN_MSB:0] clk_pin_num,
  output reg clk_pin_active,
  output reg [`PIN_MSB:0] din_pin_num,
  output reg din_pin_active
);

  // ----------------------------------------
  // Constants
  // ----------------------------------------
  localparam integer HALF_CYC_RAW = (`MIC_HALF_NS * `CLK_MHZ) / 1000;
  localparam integer HALF_CYC = (HALF_CYC_RAW < 1) ? 1 : HALF_CYC_RAW;
  localparam [5:0] HALF_LAST = HALF_CYC[5:0] - 6'h01;
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_RUN = 2'b01;
  localparam [1:0] ST_HALT = 2'b10;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [1:0] state; // Capture state
  reg ev_begun; // Capture-begun event
  reg ev_halted; // Capture-halted event
  reg ev_full; // Buffer-full event
  reg [2:0] irq_mask; // Event interrupt enables
  reg block_on; // Block enable
  reg [31:0] divider; // Clock divider setting, stored only
  reg mono; // Mono packing
  reg edge_sel; // Left on rising edge when set
  reg [`VOL_MSB:0] left_vol; // Left gain
  reg [`VOL_MSB:0] right_vol; // Right gain
  reg [31:0] clk_route; // Clock pin route
  reg [31:0] din_route; // Data pin route
  reg [31:0] ptr_next; // Pointer for the next buffer
  reg [`LEN_MSB:0] buf_len; // Buffer length in samples
  reg [31:0] cur_ptr; // Pointer of the buffer in use
  reg [`LEN_MSB:0] done_cnt; // Samples committed in this buffer
  reg [13:0] word_idx; // Word offset in this buffer
  reg [5:0] half_cnt; // Half period counter
  reg din_s1; // Synchroniser stages
  reg din_s2;
  reg din_s3;
  reg din_val; // Filtered data level
  reg [15:0] held; // Left or earlier sample awaiting a partner
  reg have_held; // Held sample valid
  reg [31:0] word; // Packed word awaiting DMA
  reg word_ready; // Packed word waiting

  // ----------------------------------------
  // Bus decode helpers
  // ----------------------------------------
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire running = (state != ST_IDLE);
  wire tick = running & (half_cnt == HALF_LAST);
  wire left_bit = tick & (mic_clock_out != edge_sel); // RQ21
  wire right_bit = tick & (mic_clock_out == edge_sel); // RQ21
  wire [15:0] left_smp;
  wire [15:0] right_smp;
  wire left_done;
  wire right_done;
  wire [`LEN_MSB:0] cnt_after = done_cnt + 15'h0002;
  wire buf_full = dma_req & dma_ack & (cnt_after >= buf_len);
  wire halt_done = (state == ST_HALT) & ~word_ready & ~dma_req;

  // Write of a one to a given offset
  function hit1;
    input [11:0] a;
    input [11:0] ofs;
    input w;
    input [31:0] d;
    begin
      hit1 = w & (a == ofs) & d[0];
    end
  endfunction

  // Offset belongs to the map
  function mapped;
    input [11:0] a;
    begin
      mapped = (a == `OFS_BEGIN) || (a == `OFS_HALT) || (a == `OFS_BEGUN) ||
               (a == `OFS_HALTED) || (a == `OFS_FULL) || (a == `OFS_IRQ_MASK) ||
               (a == `OFS_IRQ_SET) || (a == `OFS_IRQ_CLR) || (a == `OFS_BLOCK_ON) ||
               (a == `OFS_DIVIDER) || (a == `OFS_ROUTING) || (a == `OFS_LEFT_VOL) ||
               (a == `OFS_RIGHT_VOL) || (a == `OFS_CLK_PIN) || (a == `OFS_DIN_PIN) ||
               (a == `OFS_PTR) || (a == `OFS_LEN);
    end
  endfunction

  wire go = hit1(paddr, `OFS_BEGIN, wr, pwdata) & block_on & (state == ST_IDLE); // RQ17
  wire stop = hit1(paddr, `OFS_HALT, wr, pwdata) & (state == ST_RUN); // RQ17

  // ----------------------------------------
  // Decimation per channel
  // ----------------------------------------
  bit_decimator left_dec (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .clear(~running),
    .bit_valid(left_bit),
    .bit_in(din_val),
    .gain(left_vol),
    .sample(left_smp),
    .sample_valid(left_done)
  );

  bit_decimator right_dec (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .clear(~running),
    .bit_valid(right_bit),
    .bit_in(din_val),
    .gain(right_vol),
    .sample(right_smp),
    .sample_valid(right_done)
  );

  // ----------------------------------------
  // APB slave: answer in the second access cycle
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (clk_en) begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~mapped(paddr);
      prdata <= 32'h00000000;
      if (psel & penable & ~pready & ~pwrite) begin
        // Read mux; triggers and unmapped offsets read zero
        if (paddr == `OFS_BEGUN) begin
          prdata <= {31'h00000000, ev_begun}; // RQ18
        end else if (paddr == `OFS_HALTED) begin
          prdata <= {31'h00000000, ev_halted}; // RQ18
        end else if (paddr == `OFS_FULL) begin
          prdata <= {31'h00000000, ev_full}; // RQ18
        end else if ((paddr == `OFS_IRQ_MASK) || (paddr == `OFS_IRQ_SET) ||
                     (paddr == `OFS_IRQ_CLR)) begin
          prdata <= {29'h00000000, irq_mask}; // RQ20
        end else if (paddr == `OFS_BLOCK_ON) begin
          prdata <= {31'h00000000, block_on};
        end else if (paddr == `OFS_DIVIDER) begin
          prdata <= divider;
        end else if (paddr == `OFS_ROUTING) begin
          prdata <= {30'h00000000, edge_sel, mono};
        end else if (paddr == `OFS_LEFT_VOL) begin
          prdata <= {25'h0000000, left_vol};
        end else if (paddr == `OFS_RIGHT_VOL) begin
          prdata <= {25'h0000000, right_vol};
        end else if (paddr == `OFS_CLK_PIN) begin
          prdata <= clk_route;
        end else if (paddr == `OFS_DIN_PIN) begin
          prdata <= din_route;
        end else if (paddr == `OFS_PTR) begin
          prdata <= ptr_next;
        end else if (paddr == `OFS_LEN) begin
          prdata <= {17'h00000, buf_len};
        end
      end
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= 3'b000;
      block_on <= 1'b0;
      divider <= `RST_DIVIDER;
      mono <= 1'b0;
      edge_sel <= 1'b0;
      left_vol <= `RST_VOL;
      right_vol <= `RST_VOL;
      clk_route <= `RST_PIN;
      din_route <= `RST_PIN;
      ptr_next <= 32'h00000000;
      buf_len <= 15'h0000;
    end else if (clk_en && wr) begin
      if (paddr == `OFS_IRQ_MASK) begin
        irq_mask <= pwdata[2:0]; // RQ19
      end else if (paddr == `OFS_IRQ_SET) begin
        irq_mask <= irq_mask | pwdata[2:0]; // RQ20
      end else if (paddr == `OFS_IRQ_CLR) begin
        irq_mask <= irq_mask & ~pwdata[2:0]; // RQ20
      end else if (paddr == `OFS_BLOCK_ON) begin
        block_on <= pwdata[0];
      end else if (paddr == `OFS_DIVIDER) begin
        divider <= pwdata;
      end else if (paddr == `OFS_ROUTING) begin
        mono <= pwdata[`BIT_MONO];
        edge_sel <= pwdata[`BIT_EDGE]; // RQ21
      end else if (paddr == `OFS_LEFT_VOL) begin
        left_vol <= pwdata[`VOL_MSB:0];
      end else if (paddr == `OFS_RIGHT_VOL) begin
        right_vol <= pwdata[`VOL_MSB:0];
      end else if (paddr == `OFS_CLK_PIN) begin
        clk_route <= pwdata;
      end else if (paddr == `OFS_DIN_PIN) begin
        din_route <= pwdata;
      end else if (paddr == `OFS_PTR) begin
        // Only the shadow changes; the buffer in use keeps cur_ptr
        ptr_next <= pwdata; // RQ6
      end else if (paddr == `OFS_LEN) begin
        buf_len <= pwdata[`LEN_MSB:0]; // RQ4
      end
    end
  end

  // ----------------------------------------
  // Event flags: hardware set beats software write
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_begun <= 1'b0;
      ev_halted <= 1'b0;
      ev_full <= 1'b0;
    end else if (clk_en) begin
      if (go | buf_full) begin
        ev_begun <= 1'b1; // RQ8
      end else if (wr && paddr == `OFS_BEGUN) begin
        ev_begun <= pwdata[0]; // RQ18
      end
      if (halt_done) begin
        ev_halted <= 1'b1; // RQ22
      end else if (wr && paddr == `OFS_HALTED) begin
        ev_halted <= pwdata[0]; // RQ18
      end
      if (buf_full | halt_done) begin
        ev_full <= 1'b1; // RQ7 RQ9
      end else if (wr && paddr == `OFS_FULL) begin
        ev_full <= pwdata[0]; // RQ18
      end
    end
  end

  // ----------------------------------------
  // Data pin synchroniser, three stages
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      din_s1 <= 1'b0;
      din_s2 <= 1'b0;
      din_s3 <= 1'b0;
      din_val <= 1'b0;
    end else if (clk_en) begin
      din_s1 <= data_pin;
      din_s2 <= din_s1;
      din_s3 <= din_s2;
      // Accept a change only once the last two stages agree
      if (din_s2 == din_s3) begin
        din_val <= din_s3;
      end
    end
  end

  // ----------------------------------------
  // Microphone clock and pin routing
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_cnt <= 6'h00;
      mic_clock_out <= 1'b0;
      mic_clock_oe <= 1'b0;
      clk_pin_num <= 5'h1f;
      clk_pin_active <= 1'b0;
      din_pin_num <= 5'h1f;
      din_pin_active <= 1'b0;
    end else if (clk_en) begin
      // Clock parks low while idle
      if (!running) begin
        half_cnt <= 6'h00;
        mic_clock_out <= 1'b0;
      end else if (tick) begin
        half_cnt <= 6'h00;
        mic_clock_out <= ~mic_clock_out;
      end else begin
        half_cnt <= half_cnt + 6'h01;
      end
      // Disabled block hands the pins back to the GPIO logic
      clk_pin_active <= block_on & ~clk_route[`BIT_CONNECT]; // RQ12 RQ13
      din_pin_active <= block_on & ~din_route[`BIT_CONNECT]; // RQ12 RQ13
      mic_clock_oe <= block_on & ~clk_route[`BIT_CONNECT]; // RQ12 RQ13
      clk_pin_num <= clk_route[`PIN_MSB:0];
      din_pin_num <= din_route[`PIN_MSB:0];
    end
  end

  // ----------------------------------------
  // Sample packing into words
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held <= 16'h0000;
      have_held <= 1'b0;
      word <= 32'h00000000;
      word_ready <= 1'b0;
    end else if (clk_en) begin
      if (!dma_req && word_ready) begin
        word_ready <= 1'b0;
      end
      if (!running || state == ST_HALT) begin
        // A lone half word is dropped on halt
        have_held <= 1'b0;
      end else if (left_done) begin
        if (mono && have_held) begin
          word <= {left_smp, held}; // RQ2
          word_ready <= 1'b1;
          have_held <= 1'b0;
        end else begin
          held <= left_smp;
          have_held <= 1'b1;
        end
      end else if (right_done && !mono && have_held) begin
        word <= {right_smp, held}; // RQ1
        word_ready <= 1'b1;
        have_held <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Capture control and DMA writes
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      cur_ptr <= 32'h00000000;
      done_cnt <= 15'h0000;
      word_idx <= 14'h0000;
      dma_req <= 1'b0;
      dma_addr <= 32'h00000000;
      dma_wdata <= 32'h00000000;
    end else if (clk_en) begin
      if (!dma_req && word_ready) begin
        // Bits [7:0] form the lowest byte address
        dma_req <= 1'b1;
        dma_addr <= cur_ptr + {16'h0000, word_idx, 2'b00}; // RQ23
        dma_wdata <= word; // RQ3
      end else if (dma_req && dma_ack) begin
        dma_req <= 1'b0;
        if (buf_full) begin
          // Next buffer starts at once from the shadow pointer
          cur_ptr <= ptr_next; // RQ7 RQ8
          done_cnt <= 15'h0000;
          word_idx <= 14'h0000;
        end else begin
          done_cnt <= cnt_after; // RQ4
          word_idx <= word_idx + 14'h0001; // RQ23
        end
      end
      case (state)
        ST_IDLE: begin
          if (go) begin
            cur_ptr <= ptr_next; // RQ5
            done_cnt <= 15'h0000;
            word_idx <= 14'h0000;
            state <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (stop) begin
            state <= ST_HALT;
          end
        end
        ST_HALT: begin
          // Leave only after the last word is in memory
          if (halt_done) begin
            state <= ST_IDLE; // RQ22
          end
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// *** pdm_capture_monitor.sv ***
// Port checker for the microphone capture block
`timescale 1ns/1ps
`default_nettype none

module pdm_capture_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic dma_req,
  input wire logic dma_ack,
  input wire logic [31:0] dma_addr,
  input wire logic [31:0] dma_wdata,
  input wire logic mic_clock_out,
  input wire logic mic_clock_oe,
  input wire logic clk_pin_active
);
  // ----------
  // Checks
  // ----------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Register side answers
  ans_time_a: assert property (psel && $rose(penable) |=> pready)
    else $error("no answer in second access cycle");
  ans_pulse_a: assert property (pready |-> psel && penable ##1 !pready)
    else $error("answer not a single pulse");
  idle_data_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside an answer");
  trig_read_a: assert property (pready && !pwrite && paddr[11:3] == 9'h0 |-> prdata == 32'h0)
    else $error("trigger read not zero");
  flag_bits_a: assert property (pready && !pwrite && paddr[11:4] == 8'h10 |-> prdata[31:1] == 0)
    else $error("event flag wider than one bit");
  mask_bits_a: assert property (pready && !pwrite && paddr[11:4] == 8'h30 |-> prdata[31:3] == 0)
    else $error("mask wider than three bits");
  // Memory writes
  dma_hold_a: assert property (dma_req && !dma_ack |=> dma_req && $stable(dma_addr) && $stable(dma_wdata))
    else $error("write request changed before acceptance");
  dma_drop_a: assert property (dma_req && dma_ack |=> !dma_req)
    else $error("write request held after acceptance");
  dma_align_a: assert property (dma_req |-> dma_addr[1:0] == 2'h0)
    else $error("word address not aligned");
  // Microphone clock and routing
  clk_high_a: assert property ($rose(mic_clock_out) |-> ##10 !mic_clock_out)
    else $error("clock high phase too long");
  clk_low_a: assert property ($fell(mic_clock_out) |=> !mic_clock_out [*8])
    else $error("clock low phase too short");
  oe_route_a: assert property (mic_clock_oe == clk_pin_active)
    else $error("clock drive disagrees with route");
  cover property (dma_req && dma_ack);
  cover property ($rose(mic_clock_out));
  cover property (pready && pslverr);
endmodule
`default_nettype wire

// *** pdm_mic_model.sv ***
// Behavioural pair of microphones sharing one data line
`timescale 1ns/1ps
`default_nettype none

module pdm_mic_model (
  input wire logic pclk,
  input wire logic mclk,
  output logic data
);
  logic [15:0] falls = 16'h0; // Falling clock edges since capture began
  logic [5:0] idle = 6'h0; // Cycles without a clock change
  logic last = 1'b0;
  // Count falls; a clock that stands still marks a fresh capture
  always @(posedge pclk) begin
    last <= mclk;
    idle <= (mclk != last) ? 6'h0 : idle + ((idle != 6'h3f) ? 6'h1 : 6'h0);
    if (last && !mclk)
      falls <= falls + 16'h1;
    else if (idle == 6'h3f)
      falls <= 16'h0;
  end
  // Left drives in the high phase, right in the low one, so one line is never floating
  // Left sends 48 ones in even frames and 40 in odd ones; right sends zeros
  assign data = mclk ? (falls[5:0] < (falls[6] ? 6'h28 : 6'h30)) : 1'b0;
endmodule
`default_nettype wire

// *** pdm_capture_tb.sv ***
// Testbench for the microphone capture block
`timescale 1ns/1ps
`default_nettype none
`include "pdm_capture_defs.vh"

module pdm_capture_tb;
  // ----------
  // Signals
  // ----------
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0, penable = 0, pwrite = 0, dma_ack = 0, e;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, dma_addr, dma_wdata, r;
  logic pready, pslverr, dma_req, mic_clock_out, mic_clock_oe, data_pin;
  logic clk_pin_active, din_pin_active;
  logic [4:0] clk_pin_num, din_pin_num;
  logic [63:0] q[$]; // Accepted words: address, data
  logic [2:0] stall = 3'h0;
  int failures = 0, n_compared = 0;
  localparam logic [31:0] P0 = 32'h20000100, P1 = 32'h20000800, P2 = 32'h20000400;
  // Decimated values of the model's ones counts at reset volume
  localparam logic [15:0] L48 = 16'((48 - 32) * (`RST_VOL + 1) * 8);
  localparam logic [15:0] L40 = 16'((40 - 32) * (`RST_VOL + 1) * 8);
  localparam logic [15:0] RZ = 16'((0 - 32) * (`RST_VOL + 1) * 8);

  initial forever #25 pclk = ~pclk;

  pdm_capture i_pdm_capture (.pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .dma_req, .dma_addr, .dma_wdata,
    .dma_ack, .mic_clock_out, .mic_clock_oe, .data_pin, .clk_pin_num, .clk_pin_active,
    .din_pin_num, .din_pin_active);
  pdm_mic_model i_pdm_mic_model (.pclk, .mclk(mic_clock_out), .data(data_pin));

  // Memory: accepts each word after a short stall, so requests must hold
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_ack <= 0;
      stall <= 3'h0;
    end else if (dma_req && dma_ack) begin
      dma_ack <= 0;
      stall <= 3'h0;
      q.push_back({dma_addr, dma_wdata});
    end else if (dma_req) begin
      stall <= stall + 3'h1;
      dma_ack <= (stall == 3'h2);
    end
  end

  // ----------
  // Helpers
  // ----------
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // One bus transfer; answer taken at the rising edge where pready is high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
    if (n >= 20) failures++;
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [11:0] a);
    apb(0, a, 32'h0);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  task automatic poll(input logic [11:0] a);
    int n;
    n = 0;
    do rd(a); while (r !== 32'h1 && ++n < 500);
  endtask
  task automatic words(input int n);
    int k;
    k = 0;
    while (q.size() < n && k++ < 6000) @(posedge pclk);
    wt(4);
  endtask
  // Program a four-sample buffer and start
  task automatic go(input logic [31:0] mode, ptr);
    q.delete();
    apb(1, `OFS_ROUTING, mode);
    apb(1, `OFS_PTR, ptr);
    apb(1, `OFS_LEN, 32'h4);
    apb(1, `OFS_BEGUN, 32'h0);
    apb(1, `OFS_BEGIN, 32'h1);
    poll(`OFS_BEGUN);
    chk("begun", r, 32'h1);
  endtask
  task automatic halt_wait;
    apb(1, `OFS_FULL, 32'h0);
    apb(1, `OFS_HALT, 32'h1);
    poll(`OFS_HALTED);
    chk("halted", r, 32'h1);
    wt(0);
    chk("dma idle", dma_req, 32'h0);
    rd(`OFS_FULL);
    chk("full at halt", r, 32'h1);
    apb(1, `OFS_HALTED, 32'h0);
    wt(80);
    chk("clock still", mic_clock_out, 32'h0);
  endtask

  // ----------
  // Scenarios
  // ----------
  task automatic t_reset;
    logic [11:0] ofs [14] = '{`OFS_BEGIN, `OFS_HALT, `OFS_BEGUN, `OFS_HALTED, `OFS_FULL,
      `OFS_IRQ_MASK, `OFS_BLOCK_ON, `OFS_DIVIDER, `OFS_LEFT_VOL, `OFS_RIGHT_VOL,
      `OFS_CLK_PIN, `OFS_DIN_PIN, `OFS_PTR, `OFS_LEN};
    logic [31:0] val [14] = '{0, 0, 0, 0, 0, 0, 0, `RST_DIVIDER, `RST_VOL, `RST_VOL,
      `RST_PIN, `RST_PIN, 0, 0};
    foreach (ofs[i]) begin
      rd(ofs[i]);
      chk($sformatf("reset of %h", ofs[i]), r, val[i]);
    end
    rd(12'h200);
    chk("unmapped error", e, 32'h1);
    $display("reset values done");
  endtask
  task automatic t_irq;
    apb(1, `OFS_IRQ_SET, 32'h5);
    apb(1, `OFS_IRQ_SET, 32'h0);
    rd(`OFS_IRQ_MASK);
    chk("mask after set", r, 32'h5);
    apb(1, `OFS_IRQ_CLR, 32'h1);
    rd(`OFS_IRQ_CLR);
    chk("mask after clear", r, 32'h4);
    apb(1, `OFS_IRQ_MASK, 32'h3);
    rd(`OFS_IRQ_SET);
    chk("mask direct", r, 32'h3);
    $display("interrupt mask done");
  endtask
  task automatic t_pins;
    apb(1, `OFS_CLK_PIN, 32'h7);
    apb(1, `OFS_DIN_PIN, 32'h9);
    wt(1);
    chk("routed while off", {clk_pin_active, din_pin_active, mic_clock_oe}, 32'h0);
    apb(1, `OFS_BLOCK_ON, 32'h1);
    wt(1);
    chk("routed while on", {clk_pin_active, din_pin_active, mic_clock_oe}, 32'h7);
    chk("pin numbers", {clk_pin_num, din_pin_num}, {5'h7, 5'h9});
    apb(1, `OFS_CLK_PIN, 32'h80000007);
    wt(1);
    chk("clock route cut", {clk_pin_active, mic_clock_oe}, 32'h0);
    apb(1, `OFS_CLK_PIN, 32'h7);
    $display("pin routing done");
  endtask
  task automatic t_stereo;
    go(32'h0, P0);
    apb(1, `OFS_BEGUN, 32'h0);
    apb(1, `OFS_PTR, P1);
    words(3);
    chk("word0 addr", q[0][63:32], P0);
    chk("word0 data", q[0][31:0], {RZ, L48});
    chk("word1 addr", q[1][63:32], P0 + 32'h4);
    chk("word1 data", q[1][31:0], {RZ, L40});
    chk("word2 addr", q[2][63:32], P1);
    chk("word2 data", q[2][31:0], {RZ, L48});
    rd(`OFS_FULL);
    chk("full", r, 32'h1);
    rd(`OFS_BEGUN);
    chk("begun again", r, 32'h1);
    halt_wait;
    $display("stereo capture done");
  endtask
  task automatic t_mono;
    go(1 << `BIT_MONO, P2);
    words(1);
    chk("mono addr", q[0][63:32], P2);
    chk("mono data", q[0][31:0], {L40, L48});
    halt_wait;
    $display("mono capture done");
  endtask
  task automatic t_swap;
    go(1 << `BIT_EDGE, P2);
    words(1);
    chk("swapped data", q[0][31:0], {L48, RZ});
    halt_wait;
    $display("edge swap done");
  endtask

  task automatic end_of_test;
    $display("compared %0d, mismatched %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1;
    t_reset;
    t_irq;
    t_pins;
    t_stereo;
    t_mono;
    t_swap;
    end_of_test;
  end
  // Watchdog well beyond the expected run of about 9500 cycles
  initial begin
    repeat (60000) @(posedge pclk);
    failures++;
    end_of_test;
  end
endmodule

bind pdm_capture pdm_capture_monitor i_pdm_capture_monitor (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .prdata, .pready, .pslverr, .dma_req, .dma_ack, .dma_addr,
  .dma_wdata, .mic_clock_out, .mic_clock_oe, .clk_pin_active);
`default_nettype wire
